// ---- src/status_lamp_pkg.sv ----
package status_lamp_pkg;

  // Timing figures in milliseconds; the clock runs at 20 MHz.
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned FLASH_ON_MS    = 150;
  localparam int unsigned FLASH_OFF_MS   = 150;
  localparam int unsigned CODE_PAUSE_MS  = 1000;
  localparam int unsigned ROUND_PAUSE_MS = 2000;
  localparam int unsigned ID_PAUSE_MS    = 1500;
  localparam int unsigned INIT_LAMP_MS   = 500;
  localparam int unsigned ACT_BLINK_MS   = 50;

  localparam int unsigned FLASH_ON_CYC    = FLASH_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_OFF_CYC   = FLASH_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned CODE_PAUSE_CYC  = CODE_PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned ROUND_PAUSE_CYC = ROUND_PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned ID_PAUSE_CYC    = ID_PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_LAMP_CYC   = INIT_LAMP_MS * (CLK_HZ / 1000);
  localparam int unsigned ACT_BLINK_CYC   = ACT_BLINK_MS * (CLK_HZ / 1000);

  // Fault slots in rotation order and their flash counts.
  localparam int unsigned NUM_FAULTS = 4;
  localparam logic [2:0] FLASHES_FAN  = 3'h2;
  localparam logic [2:0] FLASHES_MAIN = 3'h3;
  localparam logic [2:0] FLASHES_BKUP = 3'h5;
  localparam logic [2:0] FLASHES_TEMP = 3'h6;

  typedef struct packed {
    logic fan_slow;
    logic main_supply_failed;
    logic backup_no_power;
    logic over_temp;
  } fault_set_t;

  typedef struct packed {
    logic module_present;
    logic cables_installed;
    logic [1:0] link_up;
    logic [1:0] traffic;
  } stack_state_t;

endpackage

// ---- src/flash_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Emits bursts of count flashes, then holds off for a pause chosen per burst.
module flash_sequencer
  import status_lamp_pkg::*;
#(
  parameter int unsigned ON_CYC  = FLASH_ON_CYC,
  parameter int unsigned OFF_CYC = FLASH_OFF_CYC
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // Burst request
  input  wire logic        start_in,
  input  wire logic [3:0]  count_in,
  input  wire logic [31:0] pause_in,
  // Results
  output logic             lamp_out,
  output logic             busy_out,
  output logic             done_out
);

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ON    = 2'b01,
    S_OFF   = 2'b10,
    S_PAUSE = 2'b11
  } seq_state_t;

  seq_state_t  state_ff;
  logic [31:0] timer_ff;
  logic [3:0]  left_ff;
  logic [31:0] pause_ff;
  logic        lamp_ff;
  logic        done_ff;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= S_IDLE;
      timer_ff <= 32'h0;
      left_ff  <= 4'h0;
      pause_ff <= 32'h0;
      lamp_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        S_IDLE: begin
          if (start_in && count_in != 4'h0) begin
            state_ff <= S_ON;
            timer_ff <= ON_CYC - 1;
            left_ff  <= count_in;
            pause_ff <= pause_in;
            lamp_ff  <= 1'b1;
          end
        end
        S_ON: begin
          if (timer_ff == 32'h0) begin
            state_ff <= S_OFF;
            timer_ff <= OFF_CYC - 1;
            left_ff  <= left_ff - 4'h1;
            lamp_ff  <= 1'b0;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
        S_OFF: begin
          if (timer_ff != 32'h0) begin
            timer_ff <= timer_ff - 32'h1;
          end else if (left_ff != 4'h0) begin
            state_ff <= S_ON;
            timer_ff <= ON_CYC - 1;
            lamp_ff  <= 1'b1;
          end else begin
            state_ff <= S_PAUSE;
            timer_ff <= pause_ff;
          end
        end
        S_PAUSE: begin
          if (timer_ff == 32'h0) begin
            state_ff <= S_IDLE;
            done_ff  <= 1'b1;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
      endcase
    end
  end

  assign lamp_out = lamp_ff;
  assign busy_out = (state_ff != S_IDLE);
  assign done_out = done_ff;

endmodule
`default_nettype wire

// ---- src/system_status_led_controller.sv ----
// Notes on behaviour
// RL1: Fault lamp lit briefly after init, then off.
// RL2: Fault code flashes, pauses, then repeats.
// RL3: Multiple faults shown in turn, then pause.
// RL4: Slow fan gives two flashes.
// RL5: Main supply failed on backup: three flashes.
// RL6: Backup attached without power: five flashes.
// RL7: Over temperature gives six flashes.
// RL8: One and four flash codes never produced.
// RL9: Role lamp solid while stack master.
// RL10: Role lamp flashes member ID on request.
// RL11: Backup lamp solid while backup attached.
// RL12: Power lamp solid while powered.
// RL13: Rear ready lamp solid while backup powered.
// RL14: Stacking lamps off without module or cables.
// RL15: Stacking master lamp solid only for master.
// RL16: Stack link lamps off, solid, flashing traffic.
// RL17: Presence lamp solid when module installed.
// RL18: Durations are clock-derived parameters.
`timescale 1ns/1ps
`default_nettype none
module system_status_led_controller
  import status_lamp_pkg::*;
#(
  // Off time keeps its ratio to the on time, so a design on a faster clock need not override the off time.
  // Round pause keeps its ratio to the code pause only while CODE_CYC * ROUND_PAUSE_MS fits in 32 bits;
  // the default CODE_CYC does not, so ROUND_CYC defaults to 1345294 cycles, under the code pause.
  parameter int unsigned ON_CYC      = FLASH_ON_CYC,
  parameter int unsigned OFF_CYC     = ON_CYC * FLASH_OFF_MS / FLASH_ON_MS,
  parameter int unsigned CODE_CYC    = CODE_PAUSE_CYC,
  parameter int unsigned ROUND_CYC   = CODE_CYC * ROUND_PAUSE_MS / CODE_PAUSE_MS,
  parameter int unsigned ID_CYC      = ID_PAUSE_CYC,
  parameter int unsigned INIT_CYC    = INIT_LAMP_CYC,
  parameter int unsigned ACT_CYC     = ACT_BLINK_CYC
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  // System status
  input  wire logic         hw_init_done_in,
  input  wire fault_set_t   faults_in,
  input  wire logic         power_good_in,
  input  wire logic         backup_attached_in,
  input  wire logic         backup_powered_in,
  // Stack status
  input  wire logic         stack_master_in,
  input  wire logic         show_member_id_in,
  input  wire logic [3:0]   member_id_in,
  input  wire stack_state_t stack_in,
  // Front panel lamps
  output logic              fault_lamp_out,
  output logic              role_lamp_out,
  output logic              backup_supply_lamp_out,
  output logic              power_lamp_out,
  // Rear panel lamps
  output logic              backup_ready_lamp_out,
  output logic              stacking_master_lamp_out,
  output logic [1:0]        stack_link_lamp_out,
  output logic              module_presence_lamp_out
);

  // Flash counts by slot; codes one and four have no slot and cannot appear.
  localparam logic [2:0] FLASH_TABLE [NUM_FAULTS] =
    '{FLASHES_FAN, FLASHES_MAIN, FLASHES_BKUP, FLASHES_TEMP}; // RL8

  typedef enum logic [1:0] {
    F_WAIT_INIT = 2'b00,
    F_INIT_LAMP = 2'b01,
    F_RUN       = 2'b10
  } fault_state_t;

  // Slot order is the rotation order: fan, main supply, backup supply, temperature.
  logic [NUM_FAULTS-1:0] fault_vec;
  assign fault_vec = {faults_in.over_temp, faults_in.backup_no_power,
                      faults_in.main_supply_failed, faults_in.fan_slow};

  fault_state_t fstate_ff;
  logic [31:0]  init_timer_ff;
  logic [1:0]   slot_ff;

  // Fault sequencer request path.
  logic        f_start;
  logic [3:0]  f_count;
  logic [31:0] f_pause;
  logic        f_lamp;
  logic        f_busy;

  // Next active slot at or after the current one, and whether it ends the round.
  // A fault that clears before its turn is simply skipped at the next choice.
  logic [1:0] nxt_slot;
  logic       found;
  logic       last_in_round;
  always_comb begin
    nxt_slot      = slot_ff;
    found         = 1'b0;
    last_in_round = 1'b1;
    for (int i = 0; i < NUM_FAULTS; i++) begin
      if (!found && (int'(slot_ff) + i) < NUM_FAULTS &&
          fault_vec[2'(int'(slot_ff) + i)]) begin
        nxt_slot = 2'(int'(slot_ff) + i);
        found    = 1'b1;
      end
    end
    for (int j = 0; j < NUM_FAULTS; j++) begin
      if (found && j > int'(nxt_slot) && fault_vec[j]) begin
        last_in_round = 1'b0;
      end
    end
  end

  // A code starts only from idle, so the fault set is sampled once per code.
  assign f_start = (fstate_ff == F_RUN) && !f_busy && found;
  assign f_count = {1'b0, FLASH_TABLE[nxt_slot]}; // RL4 RL5 RL6 RL7
  // A lone fault repeats after the code pause; the end of a multi-fault round
  // takes the round pause so the viewer can tell where the rotation restarts.
  assign f_pause = (last_in_round && (fault_vec != (NUM_FAULTS'(1) << nxt_slot)))
                   ? 32'(ROUND_CYC) : 32'(CODE_CYC); // RL2 RL3

  // The init flash plays once per reset. F_RUN holds until the next reset, so a
  // glitch on the init-done level cannot replay the flash over a fault code and
  // make it read as a one-flash code.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fstate_ff     <= F_WAIT_INIT;
      init_timer_ff <= 32'h0;
    end else begin
      unique case (fstate_ff)
        F_WAIT_INIT: begin
          if (hw_init_done_in) begin
            fstate_ff     <= F_INIT_LAMP; // RL1
            init_timer_ff <= 32'(INIT_CYC) - 32'h1;
          end
        end
        F_INIT_LAMP: begin
          if (init_timer_ff == 32'h0) begin
            fstate_ff <= F_RUN;
          end else begin
            init_timer_ff <= init_timer_ff - 32'h1;
          end
        end
        F_RUN: begin
          fstate_ff <= F_RUN;
        end
        default: begin
          fstate_ff <= F_WAIT_INIT;
        end
      endcase
    end
  end

  // Slot pointer: advance past the shown fault, wrap to zero at round end.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      slot_ff <= 2'h0;
    end else if (f_start) begin
      slot_ff <= last_in_round ? 2'h0 : nxt_slot + 2'h1; // RL3
    end else if (fstate_ff == F_RUN && !f_busy && !found) begin
      // Nothing active from here on: wrap, so an earlier fault is found next cycle.
      slot_ff <= 2'h0;
    end
  end

  // The done strobe is not needed here: the slot logic watches busy instead.
  flash_sequencer #(
    .ON_CYC  (ON_CYC),
    .OFF_CYC (OFF_CYC)
  ) u_fault_seq (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .start_in (f_start),
    .count_in (f_count),
    .pause_in (f_pause),
    .lamp_out (f_lamp),
    .busy_out (f_busy),
    .done_out ()
  );

  // Member-ID display uses its own burst engine with the longer pause.
  logic id_start;
  logic id_lamp;
  logic id_busy;
  // A request is taken only between bursts; while one runs it is simply held.
  assign id_start = show_member_id_in && !id_busy;

  flash_sequencer #(
    .ON_CYC  (ON_CYC),
    .OFF_CYC (OFF_CYC)
  ) u_id_seq (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .start_in (id_start),
    .count_in (member_id_in),
    .pause_in (32'(ID_CYC)),
    .lamp_out (id_lamp),
    .busy_out (id_busy),
    .done_out ()
  );

  // Free-running activity blink for the stack link lamps. Traffic is a level, so
  // the lamp flashes at a steady rate however bursty the packets are.
  logic [31:0] act_timer_ff;
  logic        act_phase_ff;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      act_timer_ff <= 32'h0;
      act_phase_ff <= 1'b0;
    end else if (act_timer_ff == 32'h0) begin
      act_timer_ff <= 32'(ACT_CYC) - 32'h1; // RL18
      act_phase_ff <= ~act_phase_ff;
    end else begin
      act_timer_ff <= act_timer_ff - 32'h1;
    end
  end

  // Module and cables together gate every stacking lamp except presence, which
  // reports the module alone.
  logic stack_ok;
  assign stack_ok = stack_in.module_present && stack_in.cables_installed;

  logic [1:0] nxt_link;
  for (genvar p = 0; p < 2; p++) begin : g_link
    assign nxt_link[p] = stack_ok && stack_in.link_up[p] &&
                         (!stack_in.traffic[p] || act_phase_ff); // RL14 RL16
  end

  // Lamp registers, one process per lamp output; both link lamps share one.
  // Fault lamp: the init flash first, then whichever code the sequencer shows.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fault_lamp_out <= 1'b0;
    end else begin
      fault_lamp_out <= (fstate_ff == F_INIT_LAMP) ||
                        ((fstate_ff == F_RUN) && f_lamp); // RL1 RL2
    end
  end

  // Role lamp: a started ID burst keeps the lamp until its pause is over, so a
  // request dropped in mid-burst never leaves a short count that reads as a
  // wrong member number.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      role_lamp_out <= 1'b0;
    end else if (show_member_id_in || id_busy) begin
      role_lamp_out <= id_lamp; // RL10
    end else begin
      role_lamp_out <= stack_master_in; // RL9
    end
  end

  // Backup supply lamp: attachment alone, powered or not.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      backup_supply_lamp_out <= 1'b0;
    end else begin
      backup_supply_lamp_out <= backup_attached_in; // RL11
    end
  end

  // Power lamp.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      power_lamp_out <= 1'b0;
    end else begin
      power_lamp_out <= power_good_in; // RL12
    end
  end

  // Rear ready lamp: whether the backup supply itself has power.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      backup_ready_lamp_out <= 1'b0;
    end else begin
      backup_ready_lamp_out <= backup_powered_in; // RL13
    end
  end

  // Stacking master lamp: dark without module and cables, like the link lamps.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stacking_master_lamp_out <= 1'b0;
    end else begin
      stacking_master_lamp_out <= stack_ok && stack_master_in; // RL14 RL15
    end
  end

  // Stack link lamps: solid on link, blinking while traffic flows.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stack_link_lamp_out <= 2'h0;
    end else begin
      stack_link_lamp_out <= nxt_link; // RL16
    end
  end

  // Presence lamp: the module alone; the cables have no say in it.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      module_presence_lamp_out <= 1'b0;
    end else begin
      module_presence_lamp_out <= stack_in.module_present; // RL17
    end
  end

endmodule
`default_nettype wire

// ---- tb/status_lamp_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module status_lamp_sva
  import status_lamp_pkg::*;
(
  // Inputs
  input wire logic         clock_in,
  input wire logic         rst_in,
  input wire logic         hw_init_done_in,
  input wire logic         power_good_in,
  input wire logic         backup_attached_in,
  input wire logic         backup_powered_in,
  input wire logic         stack_master_in,
  input wire stack_state_t stack_in,
  // Lamps
  input wire logic         fault_lamp_out,
  input wire logic         backup_supply_lamp_out,
  input wire logic         power_lamp_out,
  input wire logic         backup_ready_lamp_out,
  input wire logic         stacking_master_lamp_out,
  input wire logic [1:0]   stack_link_lamp_out,
  input wire logic         module_presence_lamp_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  logic gate;
  assign gate = stack_in.module_present && stack_in.cables_installed;
  power_lamp_a: assert property (!$past(rst_in) |->
    power_lamp_out == $past(power_good_in)) else $error("power lamp");
  backup_lamp_a: assert property (!$past(rst_in) |->
    backup_supply_lamp_out == $past(backup_attached_in)) else $error("backup lamp");
  ready_lamp_a: assert property (!$past(rst_in) |->
    backup_ready_lamp_out == $past(backup_powered_in)) else $error("ready lamp");
  presence_lamp_a: assert property (!$past(rst_in) |->
    module_presence_lamp_out == $past(stack_in.module_present)) else $error("presence");
  stack_gate_a: assert property (!gate |=>
    !stacking_master_lamp_out && stack_link_lamp_out == 2'b00) else $error("stack gate");
  master_lamp_a: assert property (gate |=>
    stacking_master_lamp_out == $past(stack_master_in)) else $error("master lamp");
  link_off_a: assert property (!$past(rst_in) |->
    (stack_link_lamp_out & ~$past(stack_in.link_up)) == 2'b00) else $error("link off");
  link_solid_a: assert property (
    (gate && stack_in.link_up[1] && !stack_in.traffic[1]) [*2] |-> stack_link_lamp_out[1])
    else $error("link solid");
  // The bench runs the init lamp for eight cycles, so the count is written out here.
  init_flash_a: assert property ($rose(hw_init_done_in) |->
    ##2 fault_lamp_out [*8] ##1 !fault_lamp_out) else $error("init lamp");
  cover property ($rose(fault_lamp_out));
  cover property (stack_in.traffic[0] && $changed(stack_link_lamp_out[0]));
  cover property (gate && stack_master_in ##1 stacking_master_lamp_out);
endmodule
bind system_status_led_controller status_lamp_sva u_status_lamp_sva (
  .clock_in, .rst_in, .hw_init_done_in, .power_good_in, .backup_attached_in,
  .backup_powered_in, .stack_master_in, .stack_in, .fault_lamp_out, .backup_supply_lamp_out,
  .power_lamp_out, .backup_ready_lamp_out, .stacking_master_lamp_out, .stack_link_lamp_out,
  .module_presence_lamp_out
);
`default_nettype wire

// ---- tb/lamp_watch.sv ----
`timescale 1ns/1ps
`default_nettype none
// A viewer of one lamp: a burst closes once the lamp has stayed dark for GAP cycles.
module lamp_watch #(
  parameter int GAP = 6
) (
  // Clock and lamp
  input wire logic clock_in,
  input wire logic lamp_in
);
  int   flashes = 0;
  int   dark = 0;
  int   bursts[$];
  int   gaps[$];
  logic last_ff = 1'b0;

  always @(posedge clock_in) begin
    if (lamp_in && !last_ff) begin
      if (dark >= GAP) begin
        gaps.push_back(dark);
        flashes = 0;
      end
      flashes++;
      dark = 0;
    end else if (!lamp_in) begin
      dark++;
      if (dark == GAP && flashes > 0) bursts.push_back(flashes);
    end
    last_ff = lamp_in;
  end
endmodule
`default_nettype wire

// ---- tb/system_status_led_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module system_status_led_controller_tb
  import status_lamp_pkg::*;
;
  logic         clock_in;
  logic         rst_in;
  logic         init_done;
  logic [4:0]   misc;
  logic [3:0]   mid;
  logic [8:0]   lamps;
  logic [8:0]   want;
  fault_set_t   faults;
  stack_state_t stk;
  int           error_cnt = 0;
  int           total_checks = 0;
  int           seed = 32'h2ec36654;
  int           ones;
  int           k;
  int           exp_q[$];
  int           code_of[4] = '{6, 5, 3, 2};
  logic [3:0]   cases[8] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hf, 4'ha, 4'h5, 4'h6};

  system_status_led_controller #(.ON_CYC(4), .CODE_CYC(10),
    .ID_CYC(15), .INIT_CYC(8), .ACT_CYC(3)) u_system_status_led_controller (
    .clock_in, .rst_in, .hw_init_done_in(init_done), .faults_in(faults),
    .power_good_in(misc[4]), .backup_attached_in(misc[3]), .backup_powered_in(misc[2]),
    .stack_master_in(misc[1]), .show_member_id_in(misc[0]), .member_id_in(mid),
    .stack_in(stk), .fault_lamp_out(lamps[0]), .role_lamp_out(lamps[1]),
    .backup_supply_lamp_out(lamps[2]), .power_lamp_out(lamps[3]),
    .backup_ready_lamp_out(lamps[4]), .stacking_master_lamp_out(lamps[5]),
    .stack_link_lamp_out(lamps[7:6]), .module_presence_lamp_out(lamps[8]));
  lamp_watch u_fault_watch (.clock_in, .lamp_in(lamps[0]));
  lamp_watch u_role_watch (.clock_in, .lamp_in(lamps[1]));

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic await(ref int q[$], input int n);
    for (int i = 0; i < 600 && q.size() < n; i++) tick(1);
    if (q.size() < n) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  initial begin
    rst_in = 1'b1;
    init_done = 1'b0;
    faults = '0;
    misc = '0;
    stk = '0;
    mid = '0;
    tick(10);
    rst_in = 1'b0;
    tick(1);
    repeat (24) begin
      {misc, stk} = 11'($random(seed));
      misc[0] = 1'b0;
      stk.traffic = 2'b00;
      k = stk.module_present & stk.cables_installed;
      want = {stk.module_present, k[0] ? stk.link_up : 2'b00, k[0] & misc[1], misc[2],
              misc[4], misc[3], misc[1], 1'b0};
      tick(2);
      check(lamps, want, "static");
    end
    stk = 6'h3d;
    tick(2);
    ones = 0;
    k = 0;
    repeat (40) begin
      tick(1);
      ones += lamps[6];
      k += lamps[7];
    end
    check(ones inside {[18:22]} && k == 40, 1, "activity");
    init_done = 1'b1;
    ones = 0;
    repeat (40) begin
      tick(1);
      ones += lamps[0];
    end
    check(ones, 8, "init lamp");
    // Each case starts from reset so that the rotation always begins at the first slot.
    for (int c = 0; c < 8; c++) begin
      rst_in = 1'b1;
      init_done = 1'b0;
      faults = '0;
      tick(2);
      check(lamps, 0, "reset");
      rst_in = 1'b0;
      tick(1);
      init_done = 1'b1;
      tick(24);
      u_fault_watch.bursts.delete();
      u_fault_watch.gaps.delete();
      faults = cases[c];
      exp_q.delete();
      for (int b = 3; b >= 0; b--) if (faults[b]) exp_q.push_back(code_of[b]);
      k = exp_q.size();
      await(u_fault_watch.bursts, 2 * k);
      for (int i = 0; i < 2 * k; i++)
        check(u_fault_watch.bursts[i], exp_q[i % k], "code");
      check(u_fault_watch.gaps[k] >= (k > 1 ? 20 : 10), 1, "pause");
    end
    faults = '0;
    mid = 4'(($random(seed) & 7) + 1);
    misc = 5'b00000;
    // Let any earlier role-lamp burst close before the queues are cleared.
    tick(10);
    u_role_watch.bursts.delete();
    u_role_watch.gaps.delete();
    misc[0] = 1'b1;
    await(u_role_watch.bursts, 2);
    for (int i = 0; i < 2; i++) check(u_role_watch.bursts[i], mid, "member id");
    check(u_role_watch.gaps[1] >= 15, 1, "id pause");
    misc = 5'b00010;
    tick(150);
    check(lamps[1], 1, "role solid");
    end_of_test();
  end
endmodule
`default_nettype wire
